// ### core/adcr_consts.svh
// register offsets, field positions and reset values of the result block
`ifndef ADCR_CONSTS_SVH
`define ADCR_CONSTS_SVH
// byte addresses on the bus
`define ADCR_OFF_RES_HIGH 8'h00
`define ADCR_OFF_RES_LOW 8'h04
`define ADCR_OFF_CMP_HIGH 8'h08
`define ADCR_OFF_CMP_LOW 8'h0C
`define ADCR_OFF_CONFIG 8'h10
`define ADCR_OFF_PIN_LOW 8'h14
`define ADCR_OFF_CONTROL 8'h18
// configuration fields
`define ADCR_CFG_LOW_POWER 7
`define ADCR_CFG_DIV_HI 6
`define ADCR_CFG_DIV_LO 5
`define ADCR_CFG_LONG_SAMPLE 4
`define ADCR_CFG_MODE_HI 3
`define ADCR_CFG_MODE_LO 2
`define ADCR_CFG_SRC_HI 1
`define ADCR_CFG_SRC_LO 0
// control fields
`define ADCR_CTL_CMP_EN 0
`define ADCR_CTL_CMP_GE 1
`define ADCR_CTL_IRQ_EN 2
`define ADCR_CTL_DONE 7
// reset values
`define ADCR_RST_RESULT 8'h00
`define ADCR_RST_CMP 8'h00
`define ADCR_RST_CONFIG 8'h00
`define ADCR_RST_PIN 8'h00
// channels that really have an analog pin on this part
`define ADCR_PIN_PRESENT 8'hFF
`endif

// ### core/adcr_pkg.sv
// types shared by the result/compare/config block
package adcr_pkg;
   typedef enum logic [1:0] {
      mode_8bit = 2'b00,
      mode_rsv1 = 2'b01,
      mode_10bit = 2'b10,
      mode_rsv3 = 2'b11
   } adcr_mode_t;
   typedef enum logic [1:0] {
      src_bus = 2'b00,
      src_bus_half = 2'b01,
      src_alternate = 2'b10,
      src_async = 2'b11
   } adcr_src_t;
   typedef struct packed {
      logic done;
      logic [9:0] data;
   } adcr_conv_t;
   typedef struct packed {
      logic low_power_select;
      logic [1:0] clock_divide;
      logic long_sample_select;
      adcr_mode_t mode;
      adcr_src_t clock_source_select;
   } adcr_cfg_t;
   typedef struct packed {
      logic [7:0] res_hi;
      logic [7:0] res_lo;
      logic [7:0] cv_hi;
      logic [7:0] cv_lo;
      adcr_cfg_t cfg;
      logic [7:0] pin_dis;
      logic cmp_en;
      logic cmp_ge;
      logic irq_en;
      logic done_flag;
      logic hi_lock;
      logic [31:0] prdata;
   } adcr_state_t;
   typedef struct packed {
      logic [2:0] alt_sync;
      logic [2:0] ack_sync;
      logic alt_lvl;
      logic ack_lvl;
      logic half;
      logic [2:0] cnt;
      logic tick;
   } adcr_div_t;
endpackage

// ### core/adcr_clk_div.sv
// converter clock: source select and divide, as a tick on pclk
`timescale 1ns/10ps
`include "adcr_consts.svh"
module adcr_clk_div
   import adcr_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // selection
   input wire adcr_src_t clock_source_select,
   input wire logic [1:0] clock_divide,
   // foreign clocks, sampled as levels
   input wire logic alternate_clock,
   input wire logic async_converter_clock,
   // result
   output logic converter_clock_tick
);
   adcr_div_t st_reg, st_next;
   logic alt_rise, ack_rise, src_tick;
   logic [2:0] div_max;

   always_comb begin
      st_next = st_reg;
      alt_rise = 1'b0;
      ack_rise = 1'b0;
      st_next.alt_sync = {st_reg.alt_sync[1:0], alternate_clock};
      st_next.ack_sync = {st_reg.ack_sync[1:0], async_converter_clock};
      // a change counts once stages two and three agree
      if (st_reg.alt_sync[1] == st_reg.alt_sync[2] &&
          st_reg.alt_sync[2] != st_reg.alt_lvl) begin
         st_next.alt_lvl = st_reg.alt_sync[2];
         alt_rise = st_reg.alt_sync[2];
      end
      if (st_reg.ack_sync[1] == st_reg.ack_sync[2] &&
          st_reg.ack_sync[2] != st_reg.ack_lvl) begin
         st_next.ack_lvl = st_reg.ack_sync[2];
         ack_rise = st_reg.ack_sync[2];
      end
      st_next.half = ~st_reg.half;
      unique case (clock_source_select)
         src_bus: src_tick = 1'b1;
         src_bus_half: src_tick = st_reg.half;
         src_alternate: src_tick = alt_rise;
         src_async: src_tick = ack_rise;
      endcase
      div_max = 3'((4'h1 << clock_divide) - 4'h1);
      st_next.tick = 1'b0;
      if (src_tick) begin
         if (st_reg.cnt >= div_max) begin
            st_next.cnt = 3'h0;
            st_next.tick = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   assign converter_clock_tick = st_reg.tick;

   // the selection must hold over both cycles, or a new divide
   // written in between legally delays the tick
   a_div_by_one: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && clock_source_select == src_bus && clock_divide == 2'b00
      && $stable(clock_divide) && $stable(clock_source_select)
      ##1 clk_en && $stable(clock_divide) && $stable(clock_source_select)
      |=> converter_clock_tick)
      else $error("divide by one gives no tick every cycle");
endmodule

// ### core/adcr_result_regs.sv
// result, compare, configuration and pin-disable registers on apb
//
// Operation
// - ten-bit mode puts result bits 9:8 into result_high.
// - results update per conversion unless compare enabled and not met.
// - eight-bit mode keeps result_high upper bits at zero.
// - ten-bit read of result_high locks results until result_low read.
// - conversions finishing while locked are discarded.
// - eight-bit mode has no interlock.
// - result_low holds low eight bits, or the whole eight-bit result.
// - compare_value_high bits 1:0 compared only in ten-bit mode.
// - compare_value_low compared to low eight bits in both modes.
// - config bit 7 selects low power when set, high speed when clear.
// - config bits 6:5 divide input clock by 1, 2, 4 or 8.
// - config bit 4 selects short or long sample period.
// - config bits 3:2: 00 eight-bit, 10 ten-bit, others reserved.
// - config bits 1:0 pick bus, bus/2, alternate or async clock.
// - pin-disable bit n disables digital i/o of channel n pin.
// - bits without an analog pin store but drive nothing.
// - with compare on, result is stored unchanged only when the compare hits.
// - compare hits below level when direction 0, at/above when 1.
// - storing a result sets the done flag; irq if enabled.
`timescale 1ns/10ps
`include "adcr_consts.svh"
module adcr_result_regs
   import adcr_pkg::*;
(
   // clock, reset, freeze
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter result, same clock
   input wire adcr_conv_t conv_in,
   // foreign clocks for the divider
   input wire logic alternate_clock,
   input wire logic async_converter_clock,
   // converter controls
   output adcr_cfg_t cfg_out,
   output logic converter_clock_tick,
   output logic [7:0] pin_digital_disable,
   output logic conversion_complete_flag,
   output logic complete_irq
);
   adcr_state_t st_reg, st_next;
   logic setup, access, wr, known, ten_bit;
   logic rd_hi_setup, rd_lo_setup, mode_chg, cmp_less, cmp_hit, qualify;
   logic store;
   logic [9:0] cmp_level, res_val;
   logic [7:0] cfg_byte, ctl_byte;
   logic [31:0] rd_mux;

   assign setup = psel && !penable && clk_en;
   assign access = psel && penable && clk_en;
   assign cfg_byte = st_reg.cfg;
   assign ctl_byte = {st_reg.done_flag, 4'h0, st_reg.irq_en,
                      st_reg.cmp_ge, st_reg.cmp_en};
   assign ten_bit = st_reg.cfg.mode == mode_10bit;

   always_comb begin
      known = 1'b1;
      rd_mux = 32'h0;
      unique case (paddr)
         `ADCR_OFF_RES_HIGH: rd_mux[7:0] = st_reg.res_hi;
         `ADCR_OFF_RES_LOW: rd_mux[7:0] = st_reg.res_lo;
         `ADCR_OFF_CMP_HIGH: rd_mux[7:0] = st_reg.cv_hi;
         `ADCR_OFF_CMP_LOW: rd_mux[7:0] = st_reg.cv_lo;
         `ADCR_OFF_CONFIG: rd_mux[7:0] = cfg_byte;
         `ADCR_OFF_PIN_LOW: rd_mux[7:0] = st_reg.pin_dis;
         `ADCR_OFF_CONTROL: rd_mux[7:0] = ctl_byte;
         default: known = 1'b0;
      endcase
   end

   // unmapped addresses answer with an error, nothing stored
   assign wr = access && pwrite && pstrb[0] && known;
   // read side effects happen at setup, when the read data is captured
   assign rd_hi_setup = setup && !pwrite && paddr == `ADCR_OFF_RES_HIGH;
   assign rd_lo_setup = setup && !pwrite && paddr == `ADCR_OFF_RES_LOW;
   assign mode_chg = wr && paddr == `ADCR_OFF_CONFIG &&
      pwdata[`ADCR_CFG_MODE_HI:`ADCR_CFG_MODE_LO] != st_reg.cfg.mode;

   // compare: upper bits only count in ten-bit mode
   always_comb begin
      if (ten_bit) begin
         cmp_level = {st_reg.cv_hi[1:0], st_reg.cv_lo};
         res_val = conv_in.data;
      end else begin
         cmp_level = {2'b00, st_reg.cv_lo};
         res_val = {2'b00, conv_in.data[7:0]};
      end
   end
   assign cmp_less = res_val < cmp_level;
   assign cmp_hit = st_reg.cmp_ge ? !cmp_less : cmp_less;
   assign qualify = !st_reg.cmp_en || cmp_hit;
   // a conversion that meets the lock, a ten-bit hi read or a mode change is simply lost
   assign store = conv_in.done && clk_en && qualify && !st_reg.hi_lock &&
      !(rd_hi_setup && ten_bit) && !mode_chg;

   always_comb begin
      st_next = st_reg;
      if (setup && !pwrite) begin
         st_next.prdata = rd_mux;
      end
      if (wr) begin
         unique case (paddr)
            `ADCR_OFF_CMP_HIGH: st_next.cv_hi = pwdata[7:0];
            `ADCR_OFF_CMP_LOW: st_next.cv_lo = pwdata[7:0];
            `ADCR_OFF_CONFIG: st_next.cfg = pwdata[7:0];
            `ADCR_OFF_PIN_LOW: st_next.pin_dis = pwdata[7:0];
            `ADCR_OFF_CONTROL: begin
               st_next.cmp_en = pwdata[`ADCR_CTL_CMP_EN];
               st_next.cmp_ge = pwdata[`ADCR_CTL_CMP_GE];
               st_next.irq_en = pwdata[`ADCR_CTL_IRQ_EN];
            end
            default: st_next.cv_hi = st_reg.cv_hi; // results are read-only
         endcase
      end
      if (rd_hi_setup && ten_bit) begin
         st_next.hi_lock = 1'b1;
      end
      if (rd_lo_setup) begin
         st_next.hi_lock = 1'b0;
         st_next.done_flag = 1'b0;
      end
      if (store) begin
         st_next.res_hi = {6'h00, res_val[9:8]};
         st_next.res_lo = res_val[7:0];
         st_next.done_flag = 1'b1; // set wins over the read clear
      end
      if (mode_chg) begin
         // old data is meaningless in the new width
         st_next.res_hi = `ADCR_RST_RESULT;
         st_next.res_lo = `ADCR_RST_RESULT;
         st_next.hi_lock = 1'b0;
      end
      if (!ten_bit && !mode_chg) begin
         st_next.hi_lock = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg.res_hi <= `ADCR_RST_RESULT;
         st_reg.res_lo <= `ADCR_RST_RESULT;
         st_reg.cv_hi <= `ADCR_RST_CMP;
         st_reg.cv_lo <= `ADCR_RST_CMP;
         st_reg.cfg <= `ADCR_RST_CONFIG;
         st_reg.pin_dis <= `ADCR_RST_PIN;
         st_reg.cmp_en <= 1'b0;
         st_reg.cmp_ge <= 1'b0;
         st_reg.irq_en <= 1'b0;
         st_reg.done_flag <= 1'b0;
         st_reg.hi_lock <= 1'b0;
         st_reg.prdata <= 32'h0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   adcr_clk_div u_div (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .clock_source_select(st_reg.cfg.clock_source_select),
      .clock_divide(st_reg.cfg.clock_divide),
      .alternate_clock(alternate_clock),
      .async_converter_clock(async_converter_clock),
      .converter_clock_tick(converter_clock_tick)
   );

   // zero wait states; a frozen block holds the master off
   assign pready = clk_en;
   assign pslverr = access && !known;
   assign prdata = st_reg.prdata;
   assign cfg_out = st_reg.cfg;
   // absent channels keep their bit but never reach a pin
   assign pin_digital_disable = st_reg.pin_dis & `ADCR_PIN_PRESENT;
   assign conversion_complete_flag = st_reg.done_flag;
   assign complete_irq = st_reg.done_flag && st_reg.irq_en;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_high_zero_8bit: assert property (
      st_reg.cfg.mode == mode_8bit |-> st_reg.res_hi == 8'h00)
      else $error("result_high not zero in eight-bit mode");
   a_store_result: assert property (
      store |=> st_reg.res_lo == $past(res_val[7:0]) &&
                st_reg.res_hi[1:0] == $past(res_val[9:8]))
      else $error("qualifying conversion not stored");
   a_compare_skip: assert property (
      conv_in.done && clk_en && st_reg.cmp_en && !cmp_hit |=>
      $stable(st_reg.res_lo) || $past(mode_chg))
      else $error("failed compare changed the result");
   a_lock_discard: assert property (
      st_reg.hi_lock && conv_in.done && clk_en && !mode_chg |=>
      $stable(st_reg.res_lo) && $stable(st_reg.res_hi))
      else $error("conversion stored while locked");
   a_lock_on_read: assert property (
      rd_hi_setup && ten_bit && !mode_chg |=> st_reg.hi_lock)
      else $error("result_high read did not lock");
   a_no_lock_8bit: assert property (
      st_reg.cfg.mode != mode_10bit |-> !st_reg.hi_lock)
      else $error("interlock held outside ten-bit mode");
   a_flag_and_irq: assert property (
      store && st_reg.irq_en && !wr |=> conversion_complete_flag
      ##0 complete_irq)
      else $error("stored result did not flag or interrupt");
   a_divide_field: assert property (
      wr && paddr == `ADCR_OFF_CONFIG |=>
      cfg_out.clock_divide == $past(pwdata[6:5]) &&
      cfg_out.low_power_select == $past(pwdata[7]))
      else $error("configuration write not applied");
   a_pin_written: assert property (
      wr && paddr == `ADCR_OFF_PIN_LOW |=>
      pin_digital_disable == ($past(pwdata[7:0]) & `ADCR_PIN_PRESENT))
      else $error("pin-disable write not applied");
   a_mode_invalid: assert property (
      mode_chg |=> st_reg.res_lo == 8'h00 && !st_reg.hi_lock)
      else $error("mode change left stale result");

   c_store: cover property (store ##1 rd_hi_setup);
   c_lock_drop: cover property (st_reg.hi_lock && conv_in.done && clk_en);
   c_cmp_skip: cover property (conv_in.done && st_reg.cmp_en && !cmp_hit);
   c_mode_chg: cover property (mode_chg);
endmodule

// ### tb/adcr_conv_model.sv
// converter model: delivers a result pulse some cycles after a request
`timescale 1ns/10ps
module adcr_conv_model
   import adcr_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // request from the bench
   input wire logic req,
   input wire logic [9:0] req_data,
   input wire logic [3:0] lat,
   // result toward the block
   output adcr_conv_t conv_out
);
   logic busy;
   logic [3:0] cnt;
   logic [9:0] d;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         d <= 10'h000;
         conv_out <= '0;
      end else begin
         conv_out.done <= 1'b0;
         // data is meaningless outside the pulse, so keep it moving
         conv_out.data <= ~conv_out.data;
         if (req && !busy) begin
            busy <= 1'b1;
            cnt <= lat;
            d <= req_data;
         end else if (busy) begin
            if (cnt == 4'h0) begin
               conv_out.done <= 1'b1;
               conv_out.data <= d;
               busy <= 1'b0;
            end else begin
               cnt <= cnt - 4'h1;
            end
         end
      end
   end
endmodule

// ### tb/adcr_result_compare_config_regs_tb_top.sv
// bench for the result, compare, config and pin-disable registers
`timescale 1ns/10ps
`include "adcr_consts.svh"
module adcr_result_compare_config_regs_tb_top
   import adcr_pkg::*;
;
   logic pclk = 0, presetn = 0, clk_en = 1;
   logic psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [3:0] pstrb = 4'h0;
   logic pready, pslverr, tick, flag, irq;
   logic alt_clk = 0, ack_clk = 0, req = 0;
   logic [9:0] req_data = 10'h000;
   logic [3:0] lat = 4'h0;
   logic [7:0] pins;
   adcr_conv_t conv;
   adcr_cfg_t cfg;
   int num_errors = 0, n_tests = 0, cyc = 0, c;
   logic [31:0] rdv;
   logic err;

   adcr_result_regs adcr_result_regs_inst (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_in(conv),
      .alternate_clock(alt_clk), .async_converter_clock(ack_clk),
      .cfg_out(cfg), .converter_clock_tick(tick),
      .pin_digital_disable(pins), .conversion_complete_flag(flag),
      .complete_irq(irq));
   adcr_conv_model adcr_conv_model_inst (.pclk(pclk), .presetn(presetn),
      .req(req), .req_data(req_data), .lat(lat), .conv_out(conv));

   initial begin
      forever #10 pclk = ~pclk;
   end
   // foreign clocks: periods of 6 and 8 bus cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      alt_clk <= (cyc % 6) < 3;
      ack_clk <= (cyc % 8) < 4;
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [7:0] wd, input logic [3:0] st);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, wd};
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      // only the bench timeout ends a wait for ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 4'h1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00, 4'h0);
      chk(rdv, {24'h0, exp});
   endtask
   task automatic convert(input logic [9:0] d, input logic [3:0] l);
      int i;
      req <= 1'b1;
      req_data <= d;
      lat <= l;
      @(posedge pclk);
      req <= 1'b0;
      for (i = 0; i < 40; i++) begin
         @(posedge pclk);
         if (conv.done === 1'b1) break;
      end
      @(posedge pclk);
   endtask
   task automatic ticks(input logic [1:0] src, input logic [1:0] dv);
      int e;
      wr(`ADCR_OFF_CONFIG, {1'b0, dv, 3'b000, src});
      chk({24'h0, cfg}, {24'h0, 1'b0, dv, 3'b000, src});
      repeat (10) @(posedge pclk);
      c = 0;
      e = 96 / ((src == 2'd0 ? 1 : src == 2'd1 ? 2 : src == 2'd2 ? 6 : 8) << dv);
      repeat (96) begin
         @(posedge pclk);
         if (tick === 1'b1) c = c + 1;
      end
      chk({31'h0, c >= e - 1 && c <= e + 1}, 32'h1);
   endtask

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int a = 0; a < 7; a++) rd(8'(a * 4), 8'h00);
      apb(1'b0, 8'h1C, 8'h00, 4'h0);
      chk({31'h0, err}, 32'h1);
      chk(rdv, 32'h0);
      wr(`ADCR_OFF_CMP_HIGH, 8'h03);
      rd(`ADCR_OFF_CMP_HIGH, 8'h03);
      wr(`ADCR_OFF_CMP_LOW, 8'h5A);
      apb(1'b1, `ADCR_OFF_CMP_LOW, 8'hFF, 4'h0);
      rd(`ADCR_OFF_CMP_LOW, 8'h5A);
      wr(`ADCR_OFF_PIN_LOW, 8'hA5);
      rd(`ADCR_OFF_PIN_LOW, 8'hA5);
      chk({24'h0, pins}, 32'hA5);
      wr(`ADCR_OFF_RES_HIGH, 8'hFF);
      rd(`ADCR_OFF_RES_HIGH, 8'h00);
      for (int s = 0; s < 4; s++)
         for (int v = 0; v < 4; v++) ticks(2'(s), 2'(v));
      wr(`ADCR_OFF_CONFIG, 8'h90);
      chk({31'h0, cfg.low_power_select}, 32'h1);
      chk({31'h0, cfg.long_sample_select}, 32'h1);
      rd(`ADCR_OFF_CONFIG, 8'h90);
      // eight-bit results, done flag and irq
      wr(`ADCR_OFF_CONFIG, 8'h00);
      wr(`ADCR_OFF_CONTROL, 8'h04);
      convert(10'h3A5, 4'h0);
      chk({31'h0, irq}, 32'h1);
      rd(`ADCR_OFF_CONTROL, 8'h84);
      rd(`ADCR_OFF_RES_HIGH, 8'h00);
      convert(10'h0C3, 4'h3);
      rd(`ADCR_OFF_RES_LOW, 8'hC3);
      rd(`ADCR_OFF_CONTROL, 8'h04);
      // ten-bit results and the read interlock
      wr(`ADCR_OFF_CONFIG, 8'h08);
      rd(`ADCR_OFF_RES_LOW, 8'h00);
      convert(10'h2C3, 4'h0);
      rd(`ADCR_OFF_RES_HIGH, 8'h02);
      convert(10'h155, 4'h2);
      rd(`ADCR_OFF_RES_LOW, 8'hC3);
      rd(`ADCR_OFF_RES_HIGH, 8'h02);
      rd(`ADCR_OFF_RES_LOW, 8'hC3);
      convert(10'h155, 4'h0);
      rd(`ADCR_OFF_RES_HIGH, 8'h01);
      rd(`ADCR_OFF_RES_LOW, 8'h55);
      // ten-bit compare against level 0x200
      wr(`ADCR_OFF_CMP_HIGH, 8'h02);
      wr(`ADCR_OFF_CMP_LOW, 8'h00);
      wr(`ADCR_OFF_CONTROL, 8'h03);
      convert(10'h1FF, 4'h0);
      rd(`ADCR_OFF_RES_HIGH, 8'h01);
      rd(`ADCR_OFF_RES_LOW, 8'h55);
      convert(10'h250, 4'h1);
      rd(`ADCR_OFF_RES_HIGH, 8'h02);
      rd(`ADCR_OFF_RES_LOW, 8'h50);
      wr(`ADCR_OFF_CONTROL, 8'h01);
      convert(10'h250, 4'h0);
      rd(`ADCR_OFF_RES_HIGH, 8'h02);
      rd(`ADCR_OFF_RES_LOW, 8'h50);
      convert(10'h100, 4'h0);
      rd(`ADCR_OFF_RES_HIGH, 8'h01);
      rd(`ADCR_OFF_RES_LOW, 8'h00);
      // eight-bit compare: high compare bits play no part
      wr(`ADCR_OFF_CONFIG, 8'h00);
      wr(`ADCR_OFF_CMP_HIGH, 8'h03);
      wr(`ADCR_OFF_CMP_LOW, 8'h80);
      wr(`ADCR_OFF_CONTROL, 8'h07);
      convert(10'h370, 4'h0);
      rd(`ADCR_OFF_RES_LOW, 8'h00);
      convert(10'h085, 4'h0);
      rd(`ADCR_OFF_RES_LOW, 8'h85);
      rd(`ADCR_OFF_RES_HIGH, 8'h00);
      convert(10'h0F0, 4'h0);
      wr(`ADCR_OFF_CONTROL, 8'h01);
      chk({31'h0, irq}, 32'h0);
      chk({31'h0, flag}, 32'h1);
      // reserved resolution code acts as eight-bit, no interlock
      wr(`ADCR_OFF_CONTROL, 8'h00);
      wr(`ADCR_OFF_CONFIG, 8'h0C);
      rd(`ADCR_OFF_CONFIG, 8'h0C);
      convert(10'h3FF, 4'h0);
      rd(`ADCR_OFF_RES_HIGH, 8'h00);
      convert(10'h2E1, 4'h0);
      rd(`ADCR_OFF_RES_LOW, 8'hE1);
      rd(`ADCR_OFF_RES_HIGH, 8'h00);
      // frozen block gives no ready
      clk_en <= 1'b0;
      @(posedge pclk);
      chk({31'h0, pready}, 32'h0);
      clk_en <= 1'b1;
      @(posedge pclk);
      test_done();
   end
endmodule
